// ### verilog/pus_pkg.sv
// Purpose: shared constants for the pattern unlock serial access port
// Assumes: one 125 MHz clock, all strobes synchronous to it
// Notes:   pattern bytes are sent least significant bit first
package pus_pkg;
	localparam int          PUS_BITS       = 64;
	localparam logic [63:0] PUS_PATTERN    = 64'h5CA33AC55CA33AC5;
	localparam logic [63:0] PUS_REGS_RESET = 64'h0000000000000000;
	localparam int          PUS_RST_IGN_BIT = 8 * 4 + 4;
	localparam int          PUS_FIFO_DEPTH = 8;
	localparam int          PUS_FIFO_WIDTH = 8;
	localparam logic [6:0]  PUS_CNT_LAST   = 7'h3F;
	typedef enum logic [1:0] {
		PUS_ST_IDLE  = 2'b00,
		PUS_ST_MATCH = 2'b01,
		PUS_ST_XFER  = 2'b11,
		PUS_ST_DEAD  = 2'b10
	} pus_state_t;
endpackage

// ### verilog/pus_if.sv
// Purpose: bus strobes between host end and device end
// Assumes: strobes active low, synchronous to clk
// Notes:   one bus cycle is one clk cycle with select_in_n low
`timescale 1ns/10ps
interface pus_if;
	logic select_in_n;
	logic oe_n;
	logic we_n;
	logic data_in;
	logic data_out;
	logic reset_n;
	logic memory_select_out_n;
	modport dev (
		input  select_in_n,
		input  oe_n,
		input  we_n,
		input  data_in,
		input  reset_n,
		output data_out,
		output memory_select_out_n
	);
	modport host (
		output select_in_n,
		output oe_n,
		output we_n,
		output data_in,
		output reset_n,
		input  data_out,
		input  memory_select_out_n
	);
endinterface

// ### verilog/pus_fifo.sv
// Purpose: small valid/ready fifo used by the host end
// Assumes: single clock
// Notes:   full and empty are exact; no bypass path
`timescale 1ns/10ps
module pus_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// pointer and level update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage has no reset, contents are qualified by the level
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
endmodule

// ### verilog/pus_dev.sv
// Purpose: device end, unlock pattern matcher and serial register port
// Assumes: one bus cycle per clk with select_in_n low
// Notes:   holds eight 8-bit registers as one 64-bit word
// Notes on behaviour
// RULE_01: unlock needs 64 matching write cycles
// RULE_02: locked: pass select through to memory
// RULE_03: unlocked: memory select held high
// RULE_04: read cycle starts attempt at bit one
// RULE_05: pattern writes only unlock, never store
// RULE_06: first write compared to bit one
// RULE_07: mismatch freezes pointer, later writes ignored
// RULE_08: read during matching restarts pointer
// RULE_09: transfer only after all 64 matched
// RULE_10: write captures data, read drives data
// RULE_11: unselected cycles change no counters
// RULE_12: pattern C5 3A A3 5C twice
// RULE_13: bit 0 reg 0 through bit 7 reg 7
// RULE_14: reset low aborts unless ignore bit set
// RULE_15: pattern bytes least significant bit first
// RULE_16: after 64 transfers relock
`timescale 1ns/10ps
module pus_dev
	import pus_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	pus_if.dev        bus,
	output logic [63:0] regs_out,
	output logic        unlocked
);
	pus_state_t  st_q, st_d;
	logic [6:0]  ptr_q, ptr_d;
	logic [63:0] regs_q, regs_d;
	logic        dout_q, dout_d;
	logic        msel_q, msel_d;
	logic        rd_cyc, wr_cyc, abort;

	// RULE_11: qualify cycles
	assign rd_cyc = !bus.select_in_n && !bus.oe_n;
	assign wr_cyc = !bus.select_in_n && !bus.we_n && bus.oe_n;
	// RULE_14: reset pin abort
	assign abort = !bus.reset_n && !regs_q[PUS_RST_IGN_BIT];

	always_comb begin
		st_d = st_q;
		ptr_d = ptr_q;
		regs_d = regs_q;
		dout_d = dout_q;
		unique case (st_q)
			PUS_ST_IDLE: begin
				// RULE_04: read arms matcher
				if (rd_cyc) begin
					st_d = PUS_ST_MATCH;
					ptr_d = '0;
				end
			end
			PUS_ST_MATCH, PUS_ST_DEAD: begin
				// RULE_08: read restarts
				if (rd_cyc) begin
					st_d = PUS_ST_MATCH;
					ptr_d = '0;
				end else if (wr_cyc && st_q == PUS_ST_MATCH) begin
					// RULE_05: pattern writes never reach regs
					// RULE_06 RULE_12 RULE_15: compare bit
					if (bus.data_in == PUS_PATTERN[ptr_q[5:0]]) begin
						ptr_d = ptr_q + 7'h01;
						// RULE_01 RULE_09: full match unlocks
						if (ptr_q == PUS_CNT_LAST) begin
							st_d = PUS_ST_XFER;
							ptr_d = '0;
						end
					end else begin
						// RULE_07: freeze on mismatch
						st_d = PUS_ST_DEAD;
					end
				end
			end
			PUS_ST_XFER: begin
				// RULE_10 RULE_13: one bit per cycle
				if (rd_cyc || wr_cyc) begin
					if (wr_cyc) begin
						regs_d[ptr_q[5:0]] = bus.data_in;
					end
					ptr_d = ptr_q + 7'h01;
					// RULE_16: relock after last bit
					if (ptr_q == PUS_CNT_LAST) begin
						st_d = PUS_ST_IDLE;
						ptr_d = '0;
					end
				end
				if (rd_cyc) begin
					dout_d = regs_q[ptr_q[5:0]];
				end
			end
		endcase
		if (abort && st_q == PUS_ST_XFER) begin
			st_d = PUS_ST_IDLE;
			ptr_d = '0;
			regs_d = regs_q;
		end
	end

	// RULE_02 RULE_03: memory select routing
	// the unlocking write is still a locked cycle, so it passes through
	always_comb begin
		msel_d = (st_q == PUS_ST_XFER) ? 1'b1 : bus.select_in_n;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= PUS_ST_IDLE;
			ptr_q <= '0;
			regs_q <= PUS_REGS_RESET;
			dout_q <= 1'b0;
			msel_q <= 1'b1;
		end else begin
			st_q <= st_d;
			ptr_q <= ptr_d;
			regs_q <= regs_d;
			dout_q <= dout_d;
			msel_q <= msel_d;
		end
	end

	assign bus.data_out = dout_q;
	assign bus.memory_select_out_n = msel_q;
	assign regs_out = regs_q;
	assign unlocked = (st_q == PUS_ST_XFER);
endmodule

// ### verilog/pus_host.sv
// Purpose: host end, plays unlock sequence then 64 transfer cycles
// Assumes: user queues 8 register bytes on wr side for a write job
// Notes:   one job = read, 64 pattern writes, 64 transfers
`timescale 1ns/10ps
module pus_host
	import pus_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	pus_if.host             bus,
	input  wire logic       start,
	input  wire logic       do_write,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_valid,
	output logic            wr_ready,
	output logic [7:0]      rd_data,
	output logic            rd_valid,
	output logic            busy
);
	typedef enum logic [1:0] {
		PUS_H_IDLE = 2'b00, PUS_H_OPEN = 2'b01,
		PUS_H_PAT = 2'b11, PUS_H_XFER = 2'b10
	} pus_hstate_t;
	pus_hstate_t st_q, st_d;
	logic [6:0] cnt_q, cnt_d;
	logic       wr_q, wr_d, cei_q, cei_d, oe_q, oe_d, we_q, we_d, d_q, d_d;
	logic [7:0] sh_q, sh_d;
	logic       rv_q, rv_d;
	logic       rs_q, rs_d, tk_q, tk_d;
	logic [2:0] bc_q, bc_d;
	logic [7:0] f_data;
	logic       f_valid, f_pop;

	pus_fifo #(.WIDTH(PUS_FIFO_WIDTH), .DEPTH(PUS_FIFO_DEPTH)) u_fifo (
		.clk(clk), .rst(rst),
		.in_data(wr_data), .in_valid(wr_valid), .in_ready(wr_ready),
		.out_data(f_data), .out_valid(f_valid), .out_ready(f_pop)
	);

	// sequencer; a write job stalls on an empty fifo
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; sh_d = sh_q;
		cei_d = 1'b1; oe_d = 1'b1; we_d = 1'b1; d_d = 1'b0;
		rv_d = 1'b0; f_pop = 1'b0;
		tk_d = rs_q; bc_d = bc_q;
		unique case (st_q)
			PUS_H_IDLE: if (start) begin
				st_d = PUS_H_OPEN; wr_d = do_write; cnt_d = '0;
			end
			PUS_H_OPEN: begin
				cei_d = 1'b0; oe_d = 1'b0; st_d = PUS_H_PAT;
			end
			PUS_H_PAT: begin
				cei_d = 1'b0; we_d = 1'b0;
				d_d = PUS_PATTERN[cnt_q[5:0]];
				cnt_d = cnt_q + 7'h01;
				if (cnt_q == PUS_CNT_LAST) begin
					st_d = PUS_H_XFER; cnt_d = '0;
				end
			end
			PUS_H_XFER: begin
				if (!wr_q || f_valid) begin
					cei_d = 1'b0;
					if (wr_q) begin
						we_d = 1'b0; d_d = f_data[cnt_q[2:0]];
						f_pop = (cnt_q[2:0] == 3'h7);
					end else begin
						oe_d = 1'b0;
					end
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == PUS_CNT_LAST) st_d = PUS_H_IDLE;
				end
			end
		endcase
		// read bit appears on data_out one cycle after its strobe,
		// so take it two cycles after the strobe was decided here
		rs_d = (st_q == PUS_H_XFER) && !cei_d && !oe_d;
		if (tk_q) begin
			sh_d = {bus.data_out, sh_q[7:1]};
			bc_d = bc_q + 3'h1;
			rv_d = (bc_q == 3'h7);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= PUS_H_IDLE; cnt_q <= '0; wr_q <= 1'b0; sh_q <= '0;
			cei_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1; d_q <= 1'b0;
			rv_q <= 1'b0; rs_q <= 1'b0; tk_q <= 1'b0; bc_q <= '0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; sh_q <= sh_d;
			cei_q <= cei_d; oe_q <= oe_d; we_q <= we_d; d_q <= d_d;
			rv_q <= rv_d; rs_q <= rs_d; tk_q <= tk_d; bc_q <= bc_d;
		end
	end

	assign bus.select_in_n = cei_q;
	assign bus.oe_n = oe_q;
	assign bus.we_n = we_q;
	assign bus.data_in = d_q;
	assign bus.reset_n = 1'b1;
	assign rd_data = sh_q;
	assign rd_valid = rv_q;
	assign busy = (st_q != PUS_H_IDLE);
endmodule

// ### test/pus_assertions.sv
// Purpose: checks on the bus joining host end and device end
// Assumes: only the host end drives the strobes, reset_n stays high
// Notes:   a small tracker follows the unlock state from the strobes
`timescale 1ns/10ps
module pus_assertions
	import pus_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic select_in_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic data_in,
	input wire logic data_out,
	input wire logic reset_n,
	input wire logic memory_select_out_n
);
	logic [6:0] ptr_q, xcnt_q;
	logic       ok_q, xfer_q;
	wire        rd  = !select_in_n && !oe_n;
	wire        wr  = !select_in_n && oe_n && !we_n;
	wire        hit = data_in == PUS_PATTERN[ptr_q[5:0]];
	// tracker; reset_n aborts are left out since the host never pulls it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_q  <= 7'h00;
			xcnt_q <= 7'h00;
			ok_q   <= 1'b0;
			xfer_q <= 1'b0;
		end else if (xfer_q && (rd || wr)) begin
			xcnt_q <= xcnt_q + 7'h01;
			xfer_q <= xcnt_q != PUS_CNT_LAST;
		end else if (rd) begin
			ptr_q <= 7'h00;
			ok_q  <= 1'b1;
		end else if (wr && ok_q) begin
			ptr_q  <= ptr_q + 7'(hit);
			ok_q   <= hit && ptr_q != PUS_CNT_LAST;
			xfer_q <= hit && ptr_q == PUS_CNT_LAST;
			xcnt_q <= 7'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_last_match;
		ok_q && wr && hit && ptr_q == PUS_CNT_LAST;
	endsequence
	sequence s_xfer_cycle;
		xfer_q && !select_in_n;
	endsequence
	a_idle_ceo_high: assert property (select_in_n |=> memory_select_out_n)
		else $error("memory select low after an idle cycle");
	a_locked_pass: assert property (!xfer_q && !select_in_n |=> !memory_select_out_n)
		else $error("locked cycle not passed to memory");
	a_xfer_ceo_high: assert property (s_xfer_cycle |=> memory_select_out_n)
		else $error("memory selected during transfer");
	a_unlock_enter: assert property (s_last_match ##1 !select_in_n |=> memory_select_out_n)
		else $error("no transfer after full match");
	a_dout_holds: assert property (!(xfer_q && rd) |=> $stable(data_out))
		else $error("data out moved without a read");
	a_oe_we_excl: assert property (!select_in_n |-> oe_n || we_n)
		else $error("read and write strobes together");
	a_job_read_first: assert property ($fell(select_in_n) && !xfer_q |-> !oe_n)
		else $error("job did not open with a read");
	a_pattern_bits: assert property (ok_q && !xfer_q && wr |-> hit)
		else $error("host sent a wrong pattern bit");
endmodule

// ### test/pattern_unlock_serial_access_tb.sv
// Purpose: bench for both ends plus a hand-driven second device end
// Assumes: a host job takes about 130 cycles after start
// Notes:   the second device end gets broken sequences on purpose
`timescale 1ns/10ps
module pattern_unlock_serial_access_tb;
	import pus_pkg::*;
	localparam logic [63:0] IMG = 64'hFEDCBA9876543210;
	localparam logic [63:0] VAL = 64'h0123456789ABCDEF;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic        do_write = 1'b0;
	logic        wr_valid = 1'b0;
	logic [7:0]  wr_data = 8'h00;
	logic [7:0]  rd_data;
	logic        wr_ready, rd_valid, busy, unl, unl2, ceo2;
	logic [63:0] regs, regs2, got;
	int          n_fail = 0;
	int          n_checks = 0;
	int          ticks = 0;
	pus_if pus_if_inst ();
	pus_if b2 ();
	pus_dev pus_dev_inst (.clk(clk), .rst(rst), .bus(pus_if_inst),
		.regs_out(regs), .unlocked(unl));
	pus_dev pus_dev_inst2 (.clk(clk), .rst(rst), .bus(b2),
		.regs_out(regs2), .unlocked(unl2));
	pus_host pus_host_inst (.clk(clk), .rst(rst), .bus(pus_if_inst),
		.start(start), .do_write(do_write), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .busy(busy));
	pus_assertions pus_assertions_inst (.clk(clk), .rst(rst),
		.select_in_n(pus_if_inst.select_in_n), .oe_n(pus_if_inst.oe_n),
		.we_n(pus_if_inst.we_n), .data_in(pus_if_inst.data_in),
		.data_out(pus_if_inst.data_out), .reset_n(pus_if_inst.reset_n),
		.memory_select_out_n(pus_if_inst.memory_select_out_n));
	// 125 MHz clock
	always #4 clk = ~clk;
	// cut a hang short
	always @(posedge clk) begin
		ticks++;
		if (ticks == 3000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one cycle then one idle cycle; ceo2 keeps the answer to the cycle
	task automatic bus2(input logic sel, input logic rd, input logic d);
		b2.select_in_n <= !sel;
		b2.oe_n        <= !rd;
		b2.we_n        <= rd;
		b2.data_in     <= d;
		@(posedge clk);
		b2.select_in_n <= 1'b1;
		b2.oe_n        <= 1'b1;
		b2.we_n        <= 1'b1;
		@(negedge clk);
		ceo2 = b2.memory_select_out_n;
		@(posedge clk);
	endtask
	// unselected writes of wrong bits are slipped between pattern bits
	task automatic unlock2(input int flip);
		bus2(1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 64; i++) begin
			bus2(1'b0, 1'b0, !PUS_PATTERN[i]);
			bus2(1'b1, 1'b0, PUS_PATTERN[i] ^ (i == flip));
		end
	endtask
	task automatic host_write();
		for (int k = 0; k < 9; k++) begin
			wr_data  <= IMG[8*(k%8)+:8];
			wr_valid <= 1'b1;
			@(posedge clk);
		end
		chk(wr_ready, 1'b0);
		wr_valid <= 1'b0;
		start    <= 1'b1;
		do_write <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (134) @(posedge clk);
		chk(busy, 1'b0);
		chk(regs, IMG);
	endtask
	task automatic host_read();
		int n;
		n = 0;
		start    <= 1'b1;
		do_write <= 1'b0;
		@(posedge clk);
		start <= 1'b0;
		repeat (134) begin
			@(posedge clk);
			if (rd_valid === 1'b1) begin
				got[8*n+:8] = rd_data;
				n++;
			end
		end
		chk(got, IMG);
		chk(n, 8);
	endtask
	task automatic bad_pattern();
		unlock2(9);
		chk(unl2, 1'b0);
		chk(ceo2, 1'b0);
	endtask
	task automatic abort_unlock();
		bus2(1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 10; i++)
			bus2(1'b1, 1'b0, PUS_PATTERN[i]);
		unlock2(64);
		chk(unl2, 1'b1);
		for (int i = 0; i < 64; i++)
			bus2(1'b1, 1'b0, VAL[i]);
		chk(ceo2, 1'b1);
		chk(regs2, VAL);
		chk(unl2, 1'b0);
	endtask
	// reset_n low mid-transfer keeps bits already written, nothing more
	task automatic reset_abort();
		unlock2(64);
		for (int i = 0; i < 3; i++)
			bus2(1'b1, 1'b0, !VAL[i]);
		b2.reset_n <= 1'b0;
		@(posedge clk);
		b2.reset_n <= 1'b1;
		@(posedge clk);
		chk(unl2, 1'b0);
		chk(regs2, VAL ^ 64'h0000000000000007);
	endtask
	task automatic finish_test();
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		b2.select_in_n = 1'b1;
		b2.oe_n        = 1'b1;
		b2.we_n        = 1'b1;
		b2.data_in     = 1'b0;
		b2.reset_n     = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		host_write();
		host_read();
		bad_pattern();
		abort_unlock();
		reset_abort();
		finish_test();
	end
endmodule
